// ### rtl/cit_pkg.sv
/*
 * Shared constants and types for the configurable pin cell and core cell tile.
 * Assumes a single 20 MHz clock and configuration words written over APB.
 */
package cit_pkg;

  localparam int unsigned CIT_ADDR_W = 8;
  localparam logic [CIT_ADDR_W-1:0] CIT_PIN_CFG_OFS = 8'h00;
  localparam logic [CIT_ADDR_W-1:0] CIT_EDGE_CFG_OFS = 8'h04;
  localparam logic [CIT_ADDR_W-1:0] CIT_CORE_CFG_OFS = 8'h08;
  localparam logic [CIT_ADDR_W-1:0] CIT_LUT_OFS = 8'h0C;
  localparam logic [CIT_ADDR_W-1:0] CIT_CTRL_OFS = 8'h10;
  localparam logic [CIT_ADDR_W-1:0] CIT_STATUS_OFS = 8'h14;

  localparam int unsigned CIT_PIN_CFG_W = 9;
  localparam int unsigned CIT_CORE_CFG_W = 24;
  localparam int unsigned CIT_LUT_DEPTH = 32;
  localparam int unsigned CIT_EDGE_LINES = 2;
  localparam int unsigned CIT_STATUS_W = 7;
  localparam int unsigned CIT_CTRL_BUSY_BIT = 0;

  localparam logic [CIT_LUT_DEPTH-1:0] CIT_LUT_RESET = 32'h0000_0000;
  localparam logic [CIT_EDGE_LINES-1:0] CIT_EDGE_INV_RESET = 2'h0;
  localparam logic CIT_BUSY_RESET = 1'b1;

  typedef enum logic [1:0] {CIT_TRI_NET, CIT_TRI_ON, CIT_TRI_OFF, CIT_TRI_SPARE} cit_tri_e;
  typedef enum logic [1:0] {CIT_OPT_TWO4, CIT_OPT_ONE5, CIT_OPT_SEL, CIT_OPT_SPARE} cit_opt_e;
  typedef enum logic [1:0] {CIT_SRC_F, CIT_SRC_G, CIT_SRC_BYP, CIT_SRC_SPARE} cit_src_e;
  typedef enum logic [1:0] {CIT_OUT_F, CIT_OUT_G, CIT_OUT_Q1, CIT_OUT_Q2} cit_out_e;
  typedef enum logic [1:0] {CIT_VAR_IN2, CIT_VAR_IN3, CIT_VAR_Q1, CIT_VAR_Q2} cit_var_e;

  typedef struct packed {
    logic pull_req;
    logic hiz_inv;
    cit_tri_e tri_mode;
    logic out_inv;
    logic out_reg;
    logic out_clk_sel;
    logic in_clk_sel;
    logic in_latch;
  } cit_pin_cfg_s;

  typedef struct packed {
    cit_opt_e opt;
    logic g_var4_in5;
    logic f_var4_in5;
    cit_var_e g_sel_b;
    cit_var_e g_sel_a;
    cit_var_e f_sel_b;
    cit_var_e f_sel_a;
    cit_out_e y_sel;
    cit_out_e x_sel;
    cit_src_e src_two;
    cit_src_e src_one;
    logic clk_inv;
    logic clk_sel;
    logic hold_en;
    logic clr_en;
  } cit_core_cfg_s;

  typedef struct packed {
    logic pad_in;
    logic pin_drive_src;
    logic hiz_ctl;
    logic [CIT_EDGE_LINES-1:0] edge_clk;
  } cit_pin_side_s;

  typedef struct packed {
    logic [4:0] core_in;
    logic [1:0] timing_pin;
    logic async_clear;
    logic hold_n;
    logic bypass_input;
  } cit_core_side_s;

  localparam cit_pin_cfg_s CIT_PIN_CFG_RESET = '{
    pull_req: 1'b0, hiz_inv: 1'b0, tri_mode: CIT_TRI_OFF, out_inv: 1'b0,
    out_reg: 1'b0, out_clk_sel: 1'b0, in_clk_sel: 1'b0, in_latch: 1'b0};

  localparam cit_core_cfg_s CIT_CORE_CFG_RESET = '{
    opt: CIT_OPT_TWO4, g_var4_in5: 1'b0, f_var4_in5: 1'b0,
    g_sel_b: CIT_VAR_IN3, g_sel_a: CIT_VAR_IN2, f_sel_b: CIT_VAR_IN3, f_sel_a: CIT_VAR_IN2,
    y_sel: CIT_OUT_G, x_sel: CIT_OUT_F, src_two: CIT_SRC_G, src_one: CIT_SRC_F,
    clk_inv: 1'b0, clk_sel: 1'b0, hold_en: 1'b0, clr_en: 1'b0};

endpackage : cit_pkg

// ### rtl/cit_tile.sv
/*
 * One pin cell and one core cell of the configurable fabric, with their
 * configuration words held in an APB slave. Fabric clocks (die-edge lines and
 * the core cell's clock nets) are ordinary inputs, sampled on the system clock,
 * and the tile's storage elements act on their sampled edges and levels.
 * Assumes all inputs are synchronous to clock and the pad wire is resolved
 * outside from pad_out and pad_oe.
 */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

// Operation
// [RULE1] Pin input storage is a rising-edge flip-flop or a low-transparent latch.
// [RULE2] Clock sense is set per die-edge clock line, not per storage element.
// [RULE3] Inverted pin clock sense needs every pin cell on that net to agree.
// [RULE4] Input and output pin clocks each pick either die-edge clock line.
// [RULE5] Pin cell storage clears during configuration and while chip reset is low.
// [RULE6] Raw pad signal and stored pad signal both reach the fabric together.
// [RULE7] Pull-up may be enabled only while the pin is an input.
// [RULE8] Output data is pin_drive_src direct or through a rising-edge output flip-flop.
// [RULE9] Three-state control high floats the pin; low drives it.
// [RULE10] Buffer forced on, forced off or net controlled, with optional control inversion.
// [RULE11] One bit chooses whether output data is inverted.
// [RULE12] Open drain: user drives the same net to data and three-state control.
// [RULE13] Core cell has five inputs, clock, clear, hold, bypass and two outputs.
// [RULE14] Each flip-flop loads F, G or bypass; F or G may drive either output.
// [RULE15] Enabled async_clear high clears both flip-flops, overriding clocked loads.
// [RULE16] Core flip-flops clear during configuration and while chip reset is low.
// [RULE17] Enabled hold_n low makes both flip-flops keep state on clock edges.
// [RULE18] Each core cell picks its clock net and its active edge.
// [RULE19] The logic is a 32 by 1 table addressed by inputs and flip-flop states.
// [RULE20] Option 1 gives two four-input functions sharing input_1.
// [RULE21] Option 2 gives one five-input function; both results are equal.
// [RULE22] Option 3 lets input_5 pick between two four-input functions.
// [RULE23] Clear or hold left disabled by configuration counts as inactive.
module cit_tile
  import cit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic chip_reset_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CIT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cit_pin_side_s pin_side,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull_en,
  output logic pad_path_raw,
  output logic stored_copy,
  input wire cit_core_side_s core_side,
  output logic out_x,
  output logic out_y
);

  function automatic logic pick_var(input cit_var_e sel, input logic in2, input logic in3,
                                    input logic q1, input logic q2);
    case (sel)
      CIT_VAR_IN2: pick_var = in2;
      CIT_VAR_IN3: pick_var = in3;
      CIT_VAR_Q1: pick_var = q1;
      default: pick_var = q2;
    endcase
  endfunction : pick_var

  function automatic logic [31:0] read_mux(input logic [CIT_ADDR_W-1:0] addr,
                                           input cit_pin_cfg_s pc,
                                           input logic [CIT_EDGE_LINES-1:0] ei,
                                           input cit_core_cfg_s cc,
                                           input logic [CIT_LUT_DEPTH-1:0] lut,
                                           input logic busy,
                                           input logic [CIT_STATUS_W-1:0] st);
    case (addr)
      CIT_PIN_CFG_OFS: read_mux = {{(32 - CIT_PIN_CFG_W){1'b0}}, pc};
      CIT_EDGE_CFG_OFS: read_mux = {{(32 - CIT_EDGE_LINES){1'b0}}, ei};
      CIT_CORE_CFG_OFS: read_mux = {{(32 - CIT_CORE_CFG_W){1'b0}}, cc};
      CIT_LUT_OFS: read_mux = lut;
      CIT_CTRL_OFS: read_mux = {31'h0000_0000, busy};
      CIT_STATUS_OFS: read_mux = {{(32 - CIT_STATUS_W){1'b0}}, st};
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  cit_pin_cfg_s pin_cfg;
  cit_core_cfg_s core_cfg;
  logic [CIT_EDGE_LINES-1:0] edge_inv;
  logic [CIT_LUT_DEPTH-1:0] lut_table;
  logic cfg_busy;

  logic addr_ok;
  logic wr_now;

  logic storage_clear;
  logic [CIT_EDGE_LINES-1:0] edge_eff;
  logic [CIT_EDGE_LINES-1:0] edge_prev;
  logic [CIT_EDGE_LINES-1:0] edge_rise;
  logic in_clk_level;
  logic in_clk_rise;
  logic out_clk_rise;

  logic out_flop;
  logic out_data;
  logic hiz_eff;

  logic core_clk_eff;
  logic core_clk_prev;
  logic core_edge;
  logic state_one;
  logic state_two;
  logic clear_now;
  logic hold_now;
  logic lut_result_1;
  logic lut_result_2;
  logic f_a;
  logic f_b;
  logic g_a;
  logic g_b;
  logic f_v4;
  logic g_v4;
  logic [4:0] addr_f;
  logic [4:0] addr_g;
  logic next_state_one;
  logic next_state_two;
  logic next_out_x;
  logic next_out_y;
  logic [CIT_STATUS_W-1:0] status_word;

  // APB slave: zero wait states, read data latched in the setup cycle.
  assign addr_ok = (paddr == CIT_PIN_CFG_OFS) || (paddr == CIT_EDGE_CFG_OFS) ||
                   (paddr == CIT_CORE_CFG_OFS) || (paddr == CIT_LUT_OFS) ||
                   (paddr == CIT_CTRL_OFS) || (paddr == CIT_STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_now = psel && penable && pwrite && addr_ok;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_mux(paddr, pin_cfg, edge_inv, core_cfg, lut_table, cfg_busy, status_word);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_cfg <= CIT_PIN_CFG_RESET;
      edge_inv <= CIT_EDGE_INV_RESET;
      core_cfg <= CIT_CORE_CFG_RESET;
      lut_table <= CIT_LUT_RESET;
      cfg_busy <= CIT_BUSY_RESET;
    end else if (wr_now) begin
      case (paddr)
        CIT_PIN_CFG_OFS: pin_cfg <= cit_pin_cfg_s'(pwdata[CIT_PIN_CFG_W-1:0]);
        CIT_EDGE_CFG_OFS: edge_inv <= pwdata[CIT_EDGE_LINES-1:0];
        CIT_CORE_CFG_OFS: core_cfg <= cit_core_cfg_s'(pwdata[CIT_CORE_CFG_W-1:0]);
        CIT_LUT_OFS: lut_table <= pwdata;
        CIT_CTRL_OFS: cfg_busy <= pwdata[CIT_CTRL_BUSY_BIT];
        default: cfg_busy <= cfg_busy;
      endcase
    end
  end

  // Configuration in progress or chip reset low holds stored_copy, out_flop and both core flip-flops clear.
  assign storage_clear = cfg_busy || !chip_reset_b; // [RULE5] [RULE16]

  // Each die-edge line carries its own inverter, shared by every cell it clocks.
  // Because sense lives on the line, cells on one net cannot disagree.
  generate
    for (genvar i = 0; i < CIT_EDGE_LINES; i++) begin : g_edge
      assign edge_eff[i] = pin_side.edge_clk[i] ^ edge_inv[i]; // [RULE2] [RULE3]
      assign edge_rise[i] = edge_eff[i] && !edge_prev[i];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      edge_prev <= '0;
    end else begin
      edge_prev <= edge_eff;
    end
  end

  assign in_clk_level = edge_eff[pin_cfg.in_clk_sel]; // [RULE4]
  assign in_clk_rise = edge_rise[pin_cfg.in_clk_sel]; // [RULE4]
  assign out_clk_rise = edge_rise[pin_cfg.out_clk_sel]; // [RULE4]

  // Input storage: flip-flop on the rising sampled edge, or latch open while low.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stored_copy <= 1'b0;
    end else if (storage_clear) begin
      stored_copy <= 1'b0; // [RULE5]
    end else if (pin_cfg.in_latch ? !in_clk_level : in_clk_rise) begin
      stored_copy <= pin_side.pad_in; // [RULE1]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_path_raw <= 1'b0;
    end else begin
      pad_path_raw <= pin_side.pad_in; // [RULE6]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_flop <= 1'b0;
    end else if (storage_clear) begin
      out_flop <= 1'b0; // [RULE5]
    end else if (out_clk_rise) begin
      out_flop <= pin_side.pin_drive_src; // [RULE8]
    end
  end

  assign out_data = (pin_cfg.out_reg ? out_flop : pin_side.pin_drive_src) ^ pin_cfg.out_inv; // [RULE8] [RULE11]

  // Effective three-state control; a high level floats the pin.
  // Open drain works when the user ties hiz_ctl to the data net.
  always_comb begin
    case (pin_cfg.tri_mode)
      CIT_TRI_NET: hiz_eff = pin_side.hiz_ctl ^ pin_cfg.hiz_inv; // [RULE10] [RULE12]
      CIT_TRI_ON: hiz_eff = 1'b0; // [RULE10]
      default: hiz_eff = 1'b1; // [RULE10]
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= 1'b0;
    end else begin
      pad_out <= out_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_oe <= 1'b0;
    end else begin
      pad_oe <= !hiz_eff; // [RULE9]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_pull_en <= 1'b0;
    end else begin
      pad_pull_en <= pin_cfg.pull_req && hiz_eff; // [RULE7]
    end
  end

  // Core cell clock: selected net, per-cell sense, rising edge of the result.
  assign core_clk_eff = core_side.timing_pin[core_cfg.clk_sel] ^ core_cfg.clk_inv; // [RULE18]
  assign core_edge = core_clk_eff && !core_clk_prev; // [RULE18]

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_clk_prev <= 1'b0;
    end else begin
      core_clk_prev <= core_clk_eff;
    end
  end

  assign clear_now = core_cfg.clr_en && core_side.async_clear; // [RULE15] [RULE23]
  assign hold_now = core_cfg.hold_en && !core_side.hold_n; // [RULE17] [RULE23]

  // Table address variables; core_in[0] is input_1 up to core_in[4] as input_5.
  assign f_a = pick_var(core_cfg.f_sel_a, core_side.core_in[1], core_side.core_in[2],
                        state_one, state_two);
  assign f_b = pick_var(core_cfg.f_sel_b, core_side.core_in[1], core_side.core_in[2],
                        state_one, state_two);
  assign g_a = pick_var(core_cfg.g_sel_a, core_side.core_in[1], core_side.core_in[2],
                        state_one, state_two);
  assign g_b = pick_var(core_cfg.g_sel_b, core_side.core_in[1], core_side.core_in[2],
                        state_one, state_two);
  assign f_v4 = core_cfg.f_var4_in5 ? core_side.core_in[4] : core_side.core_in[3];
  assign g_v4 = core_cfg.g_var4_in5 ? core_side.core_in[4] : core_side.core_in[3];

  always_comb begin
    case (core_cfg.opt)
      CIT_OPT_TWO4: begin
        addr_f = {1'b0, core_side.core_in[0], f_a, f_b, f_v4}; // [RULE20]
        addr_g = {1'b1, core_side.core_in[0], g_a, g_b, g_v4}; // [RULE20]
      end
      CIT_OPT_ONE5: begin
        addr_f = {core_side.core_in[4], core_side.core_in[0], f_a, f_b,
                  core_side.core_in[3]}; // [RULE21]
        addr_g = addr_f; // [RULE21]
      end
      default: begin
        addr_f = core_side.core_in[4] ?
                 {1'b1, core_side.core_in[0], g_a, g_b, core_side.core_in[3]} :
                 {1'b0, core_side.core_in[0], f_a, f_b, core_side.core_in[3]}; // [RULE22]
        addr_g = addr_f; // [RULE22]
      end
    endcase
  end

  assign lut_result_1 = lut_table[addr_f]; // [RULE19]
  assign lut_result_2 = lut_table[addr_g]; // [RULE19]

  always_comb begin
    case (core_cfg.src_one)
      CIT_SRC_F: next_state_one = lut_result_1; // [RULE14]
      CIT_SRC_G: next_state_one = lut_result_2; // [RULE14]
      default: next_state_one = core_side.bypass_input; // [RULE14]
    endcase
    case (core_cfg.src_two)
      CIT_SRC_F: next_state_two = lut_result_1; // [RULE14]
      CIT_SRC_G: next_state_two = lut_result_2; // [RULE14]
      default: next_state_two = core_side.bypass_input; // [RULE14]
    endcase
  end

  // Clear dominates any load; hold blocks loads on clock edges.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_one <= 1'b0;
    end else if (storage_clear || clear_now) begin
      state_one <= 1'b0; // [RULE15] [RULE16]
    end else if (core_edge && !hold_now) begin
      state_one <= next_state_one; // [RULE17]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_two <= 1'b0;
    end else if (storage_clear || clear_now) begin
      state_two <= 1'b0; // [RULE15] [RULE16]
    end else if (core_edge && !hold_now) begin
      state_two <= next_state_two; // [RULE17]
    end
  end

  always_comb begin
    case (core_cfg.x_sel)
      CIT_OUT_F: next_out_x = lut_result_1; // [RULE14]
      CIT_OUT_G: next_out_x = lut_result_2; // [RULE14]
      CIT_OUT_Q1: next_out_x = state_one;
      default: next_out_x = state_two;
    endcase
    case (core_cfg.y_sel)
      CIT_OUT_F: next_out_y = lut_result_1; // [RULE14]
      CIT_OUT_G: next_out_y = lut_result_2; // [RULE14]
      CIT_OUT_Q1: next_out_y = state_one;
      default: next_out_y = state_two;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_x <= 1'b0;
    end else begin
      out_x <= next_out_x; // [RULE13]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_y <= 1'b0;
    end else begin
      out_y <= next_out_y; // [RULE13]
    end
  end

  assign status_word = {lut_result_2, lut_result_1, state_two, state_one, out_flop,
                        stored_copy, pad_path_raw};

endmodule : cit_tile

// ### sim/cit_tile_properties.sv
/*
 * Checker for the pin cell of cit_tile, bound to the tile.
 * Assumes configuration changes reach the tile only through APB writes.
 */
`timescale 1ns/100ps
module cit_tile_properties
  import cit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic chip_reset_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CIT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cit_pin_side_s pin_side,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pull_en,
  input wire logic pad_path_raw,
  input wire logic stored_copy,
  input wire cit_core_side_s core_side,
  input wire logic out_x,
  input wire logic out_y
);
  logic [8:0] pcfg;
  logic [1:0] einv;
  logic busy;
  logic eff_d;
  logic [10:0] cfg_d;
  wire wr = psel && penable && pwrite;
  wire hiz = (pcfg[6:5] == 2'h0) ? (pin_side.hiz_ctl ^ pcfg[7]) : (pcfg[6:5] != 2'h1);
  wire eff = pin_side.edge_clk[pcfg[1]] ^ einv[pcfg[1]];
  wire clr = busy || !chip_reset_b;
  wire same = (cfg_d == {einv, pcfg});
  wire take = !clr && !pcfg[0] && eff && !eff_d && same;
  wire pass = !clr && pcfg[0] && !eff;
  wire keep = !clr && same && (pcfg[0] ? eff : !(eff && !eff_d));

  // Shadow copy of the pin configuration, taken from the bus writes.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pcfg <= CIT_PIN_CFG_RESET;
      einv <= CIT_EDGE_INV_RESET;
      busy <= CIT_BUSY_RESET;
      eff_d <= 1'h0;
      cfg_d <= {CIT_EDGE_INV_RESET, CIT_PIN_CFG_RESET};
    end else begin
      if (wr && paddr == CIT_PIN_CFG_OFS) pcfg <= pwdata[8:0];
      if (wr && paddr == CIT_EDGE_CFG_OFS) einv <= pwdata[1:0];
      if (wr && paddr == CIT_CTRL_OFS) busy <= pwdata[0];
      eff_d <= eff;
      cfg_d <= {einv, pcfg};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_raw_path: assert property ($past(rst_b) |-> pad_path_raw == $past(pin_side.pad_in))
    else $error("raw pad path does not follow the pad");
  chk_drive_enable: assert property ($past(rst_b) |-> pad_oe == !$past(hiz))
    else $error("output enable wrong for three-state setting");
  chk_pull_input: assert property ($past(rst_b) |-> pad_pull_en == $past(pcfg[8] && hiz))
    else $error("pull-up enable wrong");
  chk_pull_excl: assert property (pad_pull_en |-> !pad_oe)
    else $error("pull-up on while the pin drives");
  chk_out_direct: assert property ($past(rst_b && !pcfg[3]) |->
    pad_out == $past(pin_side.pin_drive_src ^ pcfg[4]))
    else $error("direct output data wrong");
  chk_store_clear: assert property (clr |=> !stored_copy)
    else $error("input storage not cleared");
  chk_flop_take: assert property ($past(rst_b && take) |-> stored_copy == $past(pin_side.pad_in))
    else $error("input flop missed its clock edge");
  chk_latch_pass: assert property ($past(rst_b && pass) |-> stored_copy == $past(pin_side.pad_in))
    else $error("open latch does not follow the pad");
  chk_store_keep: assert property ($past(rst_b && keep) |-> $stable(stored_copy))
    else $error("input storage changed without a clock");

  cov_open_drain: cover property (pcfg[6:5] == 2'h0 && pin_side.hiz_ctl == pin_side.pin_drive_src ##1 pad_oe);
  cov_take: cover property (take);
  cov_pass: cover property (pass);
  cov_pull: cover property (pad_pull_en);
endmodule : cit_tile_properties

bind cit_tile cit_tile_properties chk_u (
  .clock(clock), .rst_b(rst_b), .chip_reset_b(chip_reset_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_side(pin_side), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pull_en(pad_pull_en), .pad_path_raw(pad_path_raw), .stored_copy(stored_copy),
  .core_side(core_side), .out_x(out_x), .out_y(out_y));

// ### sim/cit_pad_model.sv
/*
 * Model of the package pin outside the pin cell.
 * Assumes the bench never drives the pin while the cell's buffer is on.
 */
`timescale 1ns/100ps
module cit_pad_model
(
  input wire logic clock,
  input wire logic ext_en,
  input wire logic ext_val,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pull_en,
  output logic pad_in
);
  logic wander = 1'h0;

  // A floating pin is given a level that changes every cycle, never a held value.
  always @(posedge clock) wander <= ~wander;
  assign pad_in = pad_oe ? pad_out : ext_en ? ext_val : pad_pull_en ? 1'h1 : wander;
endmodule : cit_pad_model

// ### sim/cit_tile_bench.sv
/*
 * Self-checking bench for cit_tile: APB master, pin and core stimulus.
 * Assumes the pad model and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
module cit_tile_bench;
  import cit_pkg::*;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic chip_reset_b = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [CIT_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, c, t;
  logic pready, pslverr, pad_out, pad_oe, pad_pull_en, pad_path_raw, stored_copy, out_x, out_y;
  logic src = 1'h0, hiz = 1'h0, ext_en = 1'h0, ext_val = 1'h0, pad_w, s, h, a, m, sl, iv;
  logic [1:0] eclk = 2'h0, e2;
  logic [2:0] e3;
  logic [4:0] i5;
  cit_core_side_s cs = '0;
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'h4776;
  logic [7:0] ra [6] = '{CIT_PIN_CFG_OFS, CIT_EDGE_CFG_OFS, CIT_CORE_CFG_OFS, CIT_LUT_OFS,
    CIT_CTRL_OFS, 8'h18};
  logic [31:0] rv [6] = '{32'(CIT_PIN_CFG_RESET), 32'(CIT_EDGE_INV_RESET),
    32'(CIT_CORE_CFG_RESET), CIT_LUT_RESET, 32'(CIT_BUSY_RESET), 32'h0000_0000};

  always #25 clock = ~clock;

  cit_tile dut_u (.clock(clock), .rst_b(rst_b), .chip_reset_b(chip_reset_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .pin_side({pad_w, src, hiz, eclk}),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .pad_path_raw(pad_path_raw),
    .stored_copy(stored_copy), .core_side(cs), .out_x(out_x), .out_y(out_y));
  cit_pad_model model_u (.clock(clock), .ext_en(ext_en), .ext_val(ext_val), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .pad_in(pad_w));

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Drives the selected core clock low then high, or high then low when ki is 1; the other line moves the opposite way.
  task automatic kstep(input logic ks, input logic ki, input logic b, input logic hn,
    input logic ac);
    cit_core_side_s v;
    v = '{bypass_input: !b, hold_n: hn, async_clear: ac, default: '0};
    v.timing_pin = ks ? {ki, !ki} : {!ki, ki};
    cs <= v;
    wt(2);
    v.timing_pin = ~v.timing_pin;
    v.bypass_input = b;
    cs <= v;
    wt(3);
  endtask : kstep

  function automatic logic [2:0] pin_exp(input logic [31:0] pc, input logic ps, input logic ph);
    logic z;
    z = (pc[6:5] == 2'h0) ? (ph ^ pc[7]) : (pc[6:5] != 2'h1);
    return {pc[8] & z, !z, ps ^ pc[4]};
  endfunction : pin_exp

  // Core flip-flops are known to be clear, so their table variables read 0.
  function automatic logic [1:0] lut_exp(input logic [31:0] lt, input logic [31:0] k,
    input logic [4:0] i);
    logic [3:0] v;
    logic [4:0] af, ag;
    v = {2'h0, i[2], i[1]};
    af = {1'h0, i[0], v[k[13:12]], v[k[15:14]], k[20] ? i[4] : i[3]};
    ag = {1'h1, i[0], v[k[17:16]], v[k[19:18]], k[21] ? i[4] : i[3]};
    if (k[23:22] == 2'h0) return {lt[ag], lt[af]};
    if (k[23:22] == 2'h1) af = {i[4], i[0], v[k[13:12]], v[k[15:14]], i[3]};
    else af = {i[4], i[0], i[4] ? v[k[17:16]] : v[k[13:12]], i[4] ? v[k[19:18]] : v[k[15:14]], i[3]};
    return {lt[af], lt[af]};
  endfunction : lut_exp

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    wt(16);
    rst_b <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      apb(1'h0, ra[k], '0);
      chk(rd, rv[k]);
      chk(err, k == 5);
    end
    ext_en <= 1'h1;
    ext_val <= 1'h1;
    wt(2);
    eclk <= 2'h3;
    wt(3);
    chk(stored_copy, 1'h0);
    apb(1'h1, CIT_CTRL_OFS, '0);
    ext_en <= 1'h0;
    for (int k = 0; k < 24; k++) begin
      c = $random(seed);
      c[3] = 1'h0;
      c[6:5] = (k < 4) ? 2'h0 : 2'(k);
      if (k < 4) c[8:7] = 2'h2;
      if (k < 4) c[4] = 1'h0;
      apb(1'h1, CIT_PIN_CFG_OFS, {23'h0, c[8:0]});
      s = $random(seed);
      h = (k < 4) ? s : 1'($random(seed));
      src <= s;
      hiz <= h;
      wt(3);
      e3 = pin_exp(c, s, h);
      chk(pad_pull_en, e3[2]);
      chk(pad_oe, e3[1]);
      chk(pad_out, e3[0]);
      if (k < 4) chk(pad_path_raw, s);
    end
    ext_en <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      m = k[0];
      sl = k[1];
      iv = k[2];
      apb(1'h1, CIT_EDGE_CFG_OFS, {30'h0, iv & sl, iv & !sl});
      apb(1'h1, CIT_PIN_CFG_OFS, {23'h0, 4'h2, 1'h0, 1'h1, sl, sl, m});
      a = $random(seed);
      eclk <= sl ? {iv, !iv} : {!iv, iv};
      ext_val <= a;
      src <= a;
      wt(3);
      eclk <= ~eclk;
      wt(3);
      chk(stored_copy, a);
      chk(pad_out, a);
      ext_val <= !a;
      src <= !a;
      wt(3);
      chk(stored_copy, a);
      chk(pad_out, a);
      chk(pad_path_raw, !a);
      eclk <= ~eclk;
      wt(3);
      chk(stored_copy, m ? !a : a);
      chk(pad_out, a);
    end
    chip_reset_b <= 1'h0;
    wt(2);
    chk(stored_copy, 1'h0);
    chip_reset_b <= 1'h1;
    for (int k = 0; k < 16; k++) begin
      t = $random(seed);
      c = $random(seed);
      c[11:0] = {4'h4, c[7:4], 4'h0};
      c[23:22] = 2'(k);
      i5 = $random(seed);
      apb(1'h1, CIT_LUT_OFS, t);
      apb(1'h1, CIT_CORE_CFG_OFS, {8'h0, c[23:0]});
      cs <= '{core_in: i5, default: '0};
      apb(1'h0, CIT_LUT_OFS, '0);
      chk(rd, t);
      apb(1'h0, CIT_STATUS_OFS, '0);
      e2 = lut_exp(t, c, i5);
      chk(rd[6:5], e2);
      chk(out_x, e2[0]);
      chk(out_y, e2[1]);
    end
    for (int k = 0; k < 4; k++) begin
      s = k[0];
      iv = k[1];
      a = $random(seed);
      apb(1'h1, CIT_CORE_CFG_OFS, {20'h0, 8'hEE, iv, s, 2'h3});
      kstep(s, iv, a, 1'h1, 1'h0);
      chk({out_y, out_x}, {a, a});
      kstep(s, iv, !a, 1'h0, 1'h0);
      chk({out_y, out_x}, {a, a});
      kstep(s, iv, 1'h1, 1'h1, 1'h1);
      chk({out_y, out_x}, 2'h0);
      apb(1'h1, CIT_CORE_CFG_OFS, {20'h0, 8'hEE, iv, s, 2'h0});
      kstep(s, iv, 1'h1, 1'h0, 1'h1);
      chk({out_y, out_x}, 2'h3);
    end
    chip_reset_b <= 1'h0;
    wt(3);
    chk({out_y, out_x}, 2'h0);
    wrap_up();
  end
endmodule : cit_tile_bench
